// >>> shared/dsp_core_pkg.sv
`default_nettype none
package dsp_core_pkg;
	// Datapath geometry
	localparam int XLEN = 32;
	localparam int NREG = 32;
	localparam int NSIDE = 2;
	localparam int NUNIT = 4;
	// Unit slots within one side
	localparam int U_MUL = 0;
	localparam int U_LOG = 1;
	localparam int U_SHF = 2;
	localparam int U_LDS = 3;
	// Native word fields; bit 31 marks a compact word
	localparam int F_CMP = 31;
	localparam int F_OP = 26;
	localparam int F_DST = 21;
	localparam int F_S1 = 16;
	localparam int F_S2 = 11;
	// Compact word fields, low half, registers 0 to 7 only
	localparam int C_OP = 13;
	localparam int C_DST = 10;
	localparam int C_S1 = 7;
	localparam int C_S2 = 4;
	// Operation codes
	localparam logic [4:0] OP_NOP = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_AND = 5'h03;
	localparam logic [4:0] OP_OR = 5'h04, OP_XOR = 5'h05, OP_ADDSUB = 5'h06, OP_ADDSUB2 = 5'h07;
	localparam logic [4:0] OP_SADDSUB2 = 5'h08, OP_HMIN = 5'h09, OP_HMAX = 5'h0a, OP_SHL = 5'h0b;
	localparam logic [4:0] OP_SHR = 5'h0c, OP_UNPK = 5'h0d, OP_SPACK = 5'h0e, OP_BR = 5'h0f;
	localparam logic [4:0] OP_MPY32 = 5'h10, OP_MPY2 = 5'h11, OP_MPYHL = 5'h12, OP_MPYU4 = 5'h13;
	localparam logic [4:0] OP_DOTPU4 = 5'h14, OP_DDOTP = 5'h15, OP_CPLX = 5'h16, OP_CPLXR = 5'h17;
	localparam logic [4:0] OP_GMPY4 = 5'h18, OP_GMPY = 5'h19, OP_LDW = 5'h1a, OP_STW = 5'h1b;
	localparam logic [4:0] OP_ADD40 = 5'h1c, OP_BAD = 5'h1f;
	// Opcode legality per unit, one bit per opcode
	localparam logic [31:0] LEGAL_MUL = 32'h03ff_0001;
	localparam logic [31:0] LEGAL_LOG = 32'h1000_07ff;
	localparam logic [31:0] LEGAL_SHF = 32'h0000_fe3f;
	localparam logic [31:0] LEGAL_LDS = 32'h0c00_0007;
	// Exception causes
	localparam logic [1:0] EXC_NONE = 2'h0, EXC_ILLEGAL = 2'h1, EXC_PERM = 2'h2, EXC_WDOG = 2'h3;
	// Page entry: user rwx in [2:0], supervisor rwx in [5:3]
	localparam int PERM_W = 6;
	localparam int P_SUP = 3;
	localparam int P_R = 0;
	localparam int P_W = 1;
	localparam int P_X = 2;
	localparam int PAGE_SHIFT = 12;
	// Field polynomials (plain defaults)
	localparam logic [7:0] GF8_POLY = 8'h1d;
	localparam logic [31:0] GF32_POLY = 32'h0000_0087;
	localparam logic [63:0] TSC_RST = 64'h0;
	typedef enum logic [1:0] {LB_IDLE, LB_FILL, LB_RUN} loop_state_t;
	typedef struct packed {logic ill; logic pair; logic wr; logic [31:0] hi; logic [31:0] lo;} res_t;
endpackage : dsp_core_pkg
`default_nettype wire

// >>> src/dsp_core_dual_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_core_dual_datapath
	#(parameter int NPAGES = 16, parameter int LB_DEPTH = 8)
	(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [dsp_core_pkg::XLEN-1:0] ins_mul_a,
	input wire logic [dsp_core_pkg::XLEN-1:0] ins_log_a,
	input wire logic [dsp_core_pkg::XLEN-1:0] ins_shf_a,
	input wire logic [dsp_core_pkg::XLEN-1:0] ins_lds_a,
	input wire logic [dsp_core_pkg::XLEN-1:0] ins_mul_b,
	input wire logic [dsp_core_pkg::XLEN-1:0] ins_log_b,
	input wire logic [dsp_core_pkg::XLEN-1:0] ins_shf_b,
	input wire logic [dsp_core_pkg::XLEN-1:0] ins_lds_b,
	input wire logic stall,
	input wire logic supervisor,
	input wire logic [NPAGES*dsp_core_pkg::PERM_W-1:0] page_perm,
	input wire logic fetch_valid,
	input wire logic [dsp_core_pkg::XLEN-1:0] fetch_pc,
	input wire logic watchdog_expire,
	input wire logic irq,
	input wire logic loop_record,
	input wire logic loop_start,
	input wire logic [7:0] loop_count,
	input wire logic [dsp_core_pkg::XLEN-1:0] mem_rdata_a,
	input wire logic [dsp_core_pkg::XLEN-1:0] mem_rdata_b,
	input wire logic mem_rvalid_a,
	input wire logic mem_rvalid_b,
	output logic [dsp_core_pkg::XLEN-1:0] mem_addr_a_r,
	output logic [dsp_core_pkg::XLEN-1:0] mem_addr_b_r,
	output logic [dsp_core_pkg::XLEN-1:0] mem_wdata_a_r,
	output logic [dsp_core_pkg::XLEN-1:0] mem_wdata_b_r,
	output logic mem_re_a_r,
	output logic mem_re_b_r,
	output logic mem_we_a_r,
	output logic mem_we_b_r,
	output logic exc_valid_r,
	output logic [1:0] exc_cause_r,
	output logic branch_valid_r,
	output logic [dsp_core_pkg::XLEN-1:0] branch_target_r,
	output logic [63:0] tsc_r,
	output logic loop_busy_r
	);
	import dsp_core_pkg::*;
	localparam int PGW = $clog2(NPAGES);
	localparam int PW = $clog2(LB_DEPTH) + 1;

	// Saturate a signed value to a halfword
	function automatic logic [15:0] sat16(input logic signed [32:0] x);
		if (x > 33'sd32767)
			return 16'h7fff;
		if (x < -33'sd32768)
			return 16'h8000;
		return x[15:0];
	endfunction : sat16

	// Signed halfword product, sign-extended to a word
	function automatic logic [31:0] mul16s(input logic [15:0] x, input logic [15:0] y);
		logic signed [31:0] p;
		p = $signed(x) * $signed(y);
		return p;
	endfunction : mul16s

	// Unsigned byte product, a full halfword
	function automatic logic [15:0] mul8(input logic [7:0] x, input logic [7:0] y);
		return {8'h00, x} * {8'h00, y};
	endfunction : mul8

	// Saturating halfword add or subtract
	function automatic logic [15:0] s16op(input logic [15:0] x, input logic [15:0] y, input logic sub);
		logic signed [32:0] t;
		t = sub ? $signed({{17{x[15]}}, x}) - $signed({{17{y[15]}}, y}) : $signed({{17{x[15]}}, x}) + $signed({{17{y[15]}}, y});
		return sat16(t);
	endfunction : s16op

	// Signed halfword minimum or maximum
	function automatic logic [15:0] mm16(input logic [15:0] x, input logic [15:0] y, input logic mx);
		logic lt;
		lt = $signed(x) < $signed(y);
		return (lt ^ mx) ? x : y;
	endfunction : mm16

	// Galois field product over bytes
	function automatic logic [7:0] gf8(input logic [7:0] x, input logic [7:0] y);
		logic [7:0] v;
		logic [7:0] r;
		v = x;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			if (y[i])
				r = r ^ v;
			v = v[7] ? {v[6:0], 1'b0} ^ GF8_POLY : {v[6:0], 1'b0};
		end
		return r;
	endfunction : gf8

	// Galois field product over words
	function automatic logic [31:0] gf32(input logic [31:0] x, input logic [31:0] y);
		logic [31:0] v;
		logic [31:0] r;
		v = x;
		r = 32'h0;
		for (int i = 0; i < 32; i++)
		begin
			if (y[i])
				r = r ^ v;
			v = v[31] ? {v[30:0], 1'b0} ^ GF32_POLY : {v[30:0], 1'b0};
		end
		return r;
	endfunction : gf32

	// Widen a compact word; unknown compact codes become illegal
	function automatic logic [31:0] expand(input logic [31:0] w);
		logic [4:0] o;
		if (!w[F_CMP])
			return w;
		case (w[C_OP +: 3])
			3'h1: o = OP_MPY2;
			3'h2: o = OP_AND;
			3'h3: o = OP_OR;
			3'h4: o = OP_ADD;
			3'h5: o = OP_SUB;
			3'h0: o = OP_NOP;
			default: o = OP_BAD;
		endcase
		return {1'b0, o, 2'b00, w[C_DST +: 3], 2'b00, w[C_S1 +: 3], 2'b00, w[C_S2 +: 3], 11'h000};
	endfunction : expand

	// Opcode allowed on this unit kind
	function automatic logic legal(input int unit, input logic [4:0] o);
		logic [31:0] m;
		case (unit)
			U_MUL: m = LEGAL_MUL;
			U_LOG: m = LEGAL_LOG;
			U_SHF: m = LEGAL_SHF;
			default: m = LEGAL_LDS;
		endcase
		return m[o];
	endfunction : legal

	// One unit's result; pair sources are named by their even register
	function automatic res_t exec(input int unit, input logic [4:0] o, input logic [63:0] a, input logic [63:0] b);
		res_t r;
		logic [63:0] p;
		logic [39:0] s40;
		logic signed [32:0] re;
		logic signed [32:0] im;
		logic [31:0] rr; // Real times real
		logic [31:0] ii; // Imaginary times imaginary
		logic [31:0] ri; // Real times imaginary
		logic [31:0] ir; // Imaginary times real
		r = '0;
		p = $signed(a[31:0]) * $signed(b[31:0]);
		s40 = a[39:0] + {{8{b[31]}}, b[31:0]};
		rr = mul16s(a[31:16], b[31:16]);
		ii = mul16s(a[15:0], b[15:0]);
		ri = mul16s(a[31:16], b[15:0]);
		ir = mul16s(a[15:0], b[31:16]);
		re = $signed({rr[31], rr}) - $signed({ii[31], ii});
		im = $signed({ri[31], ri}) + $signed({ir[31], ir});
		r.wr = 1'b1;
		case (o)
			OP_ADD: r.lo = a[31:0] + b[31:0];
			OP_SUB: r.lo = a[31:0] - b[31:0];
			OP_AND: r.lo = a[31:0] & b[31:0];
			OP_OR: r.lo = a[31:0] | b[31:0];
			OP_XOR: r.lo = a[31:0] ^ b[31:0];
			OP_ADDSUB: {r.pair, r.hi, r.lo} = {1'b1, a[31:0] + b[31:0], a[31:0] - b[31:0]};
			OP_ADDSUB2: {r.pair, r.hi, r.lo} = {1'b1, a[31:16] + b[31:16], a[15:0] + b[15:0], a[31:16] - b[31:16], a[15:0] - b[15:0]};
			OP_SADDSUB2: {r.pair, r.hi, r.lo} = {1'b1, s16op(a[31:16], b[31:16], 1'b0), s16op(a[15:0], b[15:0], 1'b0), s16op(a[31:16], b[31:16], 1'b1), s16op(a[15:0], b[15:0], 1'b1)};
			OP_HMIN: r.lo = {mm16(a[31:16], b[31:16], 1'b0), mm16(a[15:0], b[15:0], 1'b0)};
			OP_HMAX: r.lo = {mm16(a[31:16], b[31:16], 1'b1), mm16(a[15:0], b[15:0], 1'b1)};
			OP_SHL: r.lo = a[31:0] << b[4:0];
			OP_SHR: r.lo = $signed(a[31:0]) >>> b[4:0];
			OP_UNPK: {r.pair, r.hi, r.lo} = {1'b1, 8'h00, a[31:24], 8'h00, a[23:16], 8'h00, a[15:8], 8'h00, a[7:0]};
			OP_SPACK: r.lo = {sat16({a[31], a[31:0]}), sat16({b[31], b[31:0]})};
			OP_MPY32: {r.pair, r.hi, r.lo} = {1'b1, p};
			OP_MPY2: {r.pair, r.hi, r.lo} = {1'b1, mul16s(a[31:16], b[31:16]), mul16s(a[15:0], b[15:0])};
			OP_MPYHL: {r.pair, r.hi, r.lo} = {1'b1, p[63:32], p[31:0]} ^ {1'b0, 64'h0}; // Word times word keeps both halves
			OP_MPYU4: {r.pair, r.hi, r.lo} = {1'b1, mul8(a[31:24], b[31:24]), mul8(a[23:16], b[23:16]), mul8(a[15:8], b[15:8]), mul8(a[7:0], b[7:0])};
			OP_DOTPU4: r.lo = {16'h0, mul8(a[31:24], b[31:24])} + {16'h0, mul8(a[23:16], b[23:16])} + {16'h0, mul8(a[15:8], b[15:8])} + {16'h0, mul8(a[7:0], b[7:0])};
			OP_DDOTP: {r.pair, r.hi, r.lo} = {1'b1, mul16s(a[31:16], b[31:16]) + mul16s(a[15:0], b[15:0]), mul16s(a[63:48], b[63:48]) - mul16s(a[47:32], b[47:32])};
			OP_CPLX: {r.pair, r.hi, r.lo} = {1'b1, re[31:0], im[31:0]};
			OP_CPLXR: r.lo = {sat16((re + 33'sh0_8000) >>> 16), sat16((im + 33'sh0_8000) >>> 16)};
			OP_GMPY4: r.lo = {gf8(a[31:24], b[31:24]), gf8(a[23:16], b[23:16]), gf8(a[15:8], b[15:8]), gf8(a[7:0], b[7:0])};
			OP_GMPY: r.lo = gf32(a[31:0], b[31:0]);
			OP_ADD40: {r.pair, r.hi, r.lo} = {1'b1, 24'h0, s40};
			default: r.wr = 1'b0; // No register result
		endcase
		r.ill = !legal(unit, o);
		if (r.ill)
			r.wr = 1'b0;
		return r;
	endfunction : exec

	// Architectural state
	logic [31:0] rf [NSIDE][NREG]; // Register files A and B
	logic [31:0] lb_mem [LB_DEPTH][NSIDE][NUNIT]; // Loop buffer bundles
	loop_state_t lb_state_r; // Loop buffer mode
	logic [PW-1:0] lb_pos_r; // Replay or fill position
	logic [PW-1:0] lb_len_r; // Recorded bundle count
	logic [7:0] lb_iter_r; // Iterations still to run
	logic [4:0] ld_dst_r [NSIDE]; // Pending load destination
	logic [31:0] maddr_r [NSIDE];
	logic [31:0] mwd_r [NSIDE];
	logic mre_r [NSIDE];
	logic mwe_r [NSIDE];

	// Decode and execute nets
	logic [31:0] live [NSIDE][NUNIT];
	logic [31:0] ins [NSIDE][NUNIT];
	logic [4:0] op [NSIDE][NUNIT];
	logic [4:0] dst [NSIDE][NUNIT];
	logic [4:0] lo_idx [NSIDE][NUNIT];
	logic [4:0] hi_idx [NSIDE][NUNIT];
	logic [63:0] a_v [NSIDE][NUNIT];
	logic [63:0] b_v [NSIDE][NUNIT];
	res_t res [NSIDE][NUNIT];
	logic we [NSIDE][NUNIT];
	logic [NSIDE*NUNIT-1:0] ill_v;
	logic [NSIDE-1:0] perm_bad;
	logic [NSIDE-1:0] is_ld;
	logic [NSIDE-1:0] is_st;
	logic [NSIDE-1:0] br_v;
	logic [31:0] addr [NSIDE];
	logic [31:0] rdata [NSIDE];
	logic [NSIDE-1:0] rvalid;
	wire logic iss = !stall; // Stall freezes issue, never the counter
	wire logic replay = (lb_state_r == LB_RUN) && !irq; // Interrupt takes the live bundle
	wire logic [2:0] fetch_rights = page_perm[fetch_pc[PAGE_SHIFT +: PGW]*PERM_W + (supervisor ? P_SUP : 0) +: 3];
	wire logic fetch_bad = fetch_valid && !fetch_rights[P_X];
	wire logic [1:0] exc_nxt = watchdog_expire ? EXC_WDOG : ((|perm_bad) || fetch_bad) ? EXC_PERM : (|ill_v) ? EXC_ILLEGAL : EXC_NONE;

	assign live[0] = '{ins_mul_a, ins_log_a, ins_shf_a, ins_lds_a};
	assign live[1] = '{ins_mul_b, ins_log_b, ins_shf_b, ins_lds_b};
	assign rdata = '{mem_rdata_a, mem_rdata_b};
	assign rvalid = {mem_rvalid_b, mem_rvalid_a};
	assign {mem_addr_a_r, mem_addr_b_r, mem_wdata_a_r, mem_wdata_b_r} = {maddr_r[0], maddr_r[1], mwd_r[0], mwd_r[1]};
	assign {mem_re_a_r, mem_re_b_r, mem_we_a_r, mem_we_b_r} = {mre_r[0], mre_r[1], mwe_r[0], mwe_r[1]};

	// Every unit decodes and executes in parallel each cycle
	for (genvar s = 0; s < NSIDE; s++)
	begin : g_side
		for (genvar u = 0; u < NUNIT; u++)
		begin : g_unit
			assign ins[s][u] = expand(replay ? lb_mem[lb_pos_r[PW-2:0]][s][u] : live[s][u]);
			assign op[s][u] = ins[s][u][F_OP +: 5];
			assign dst[s][u] = ins[s][u][F_DST +: 5];
			assign a_v[s][u] = {rf[s][{ins[s][u][F_S1+1 +: 4], 1'b1}], rf[s][ins[s][u][F_S1 +: 5]]};
			assign b_v[s][u] = {rf[s][{ins[s][u][F_S2+1 +: 4], 1'b1}], rf[s][ins[s][u][F_S2 +: 5]]};
			assign res[s][u] = exec(u, op[s][u], a_v[s][u], b_v[s][u]);
			assign lo_idx[s][u] = res[s][u].pair ? {dst[s][u][4:1], 1'b0} : dst[s][u];
			assign hi_idx[s][u] = {dst[s][u][4:1], 1'b1};
			assign we[s][u] = iss && res[s][u].wr;
			assign ill_v[s*NUNIT+u] = iss && res[s][u].ill;
		end
		// Load/store address, page rights and branch request
		wire logic [2:0] rights = page_perm[addr[s][PAGE_SHIFT +: PGW]*PERM_W + (supervisor ? P_SUP : 0) +: 3];
		assign addr[s] = a_v[s][U_LDS][31:0] + b_v[s][U_LDS][31:0];
		assign is_ld[s] = iss && (op[s][U_LDS] == OP_LDW);
		assign is_st[s] = iss && (op[s][U_LDS] == OP_STW);
		assign perm_bad[s] = (is_ld[s] && !rights[P_R]) || (is_st[s] && !rights[P_W]);
		assign br_v[s] = iss && (op[s][U_SHF] == OP_BR);
	end

	// Register file write-back; later units win on a clash, load return last
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rf <= '{default: '0};
		else
			for (int s = 0; s < NSIDE; s++)
			begin
				for (int u = 0; u < NUNIT; u++)
				begin
					if (we[s][u])
						rf[s][lo_idx[s][u]] <= res[s][u].lo;
					if (we[s][u] && res[s][u].pair)
						rf[s][hi_idx[s][u]] <= res[s][u].hi;
				end
				if (rvalid[s])
					rf[s][ld_dst_r[s]] <= rdata[s];
			end
	end

	// Memory requests; a refused page access never reaches the pins
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			maddr_r <= '{default: '0};
			mwd_r <= '{default: '0};
			mre_r <= '{default: 1'b0};
			mwe_r <= '{default: 1'b0};
			ld_dst_r <= '{default: '0};
		end
		else
			for (int s = 0; s < NSIDE; s++)
			begin
				maddr_r[s] <= addr[s];
				mwd_r[s] <= rf[s][dst[s][U_LDS]];
				mre_r[s] <= is_ld[s] && !perm_bad[s];
				mwe_r[s] <= is_st[s] && !perm_bad[s];
				if (is_ld[s] && !perm_bad[s])
					ld_dst_r[s] <= dst[s][U_LDS];
			end
	end

	// Exceptions, branches and the free-running counter
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{exc_valid_r, exc_cause_r, branch_valid_r, branch_target_r} <= '0;
			tsc_r <= TSC_RST;
		end
		else
		begin
			exc_valid_r <= exc_nxt != EXC_NONE;
			exc_cause_r <= exc_nxt;
			branch_valid_r <= |br_v;
			branch_target_r <= br_v[0] ? a_v[0][U_SHF][31:0] : a_v[1][U_SHF][31:0];
			tsc_r <= tsc_r + 64'h1;
		end
	end

	// Loop buffer capture; only the live bundle is recorded
	always_ff @(posedge clk)
	begin
		if (lb_state_r == LB_FILL && loop_record && iss && lb_pos_r < PW'(LB_DEPTH))
			lb_mem[lb_pos_r[PW-2:0]] <= live;
	end

	// Loop buffer control; an interrupt holds replay where it stands
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{lb_pos_r, lb_len_r, lb_iter_r, loop_busy_r} <= '0;
			lb_state_r <= LB_IDLE;
		end
		else
			case (lb_state_r)
				LB_IDLE:
					if (loop_record)
					begin
						lb_state_r <= LB_FILL;
						lb_pos_r <= PW'(0);
						loop_busy_r <= 1'b1;
					end
					else if (loop_start && lb_len_r != '0 && loop_count != 8'h00)
					begin
						lb_state_r <= LB_RUN;
						lb_pos_r <= PW'(0);
						lb_iter_r <= loop_count;
						loop_busy_r <= 1'b1;
					end
				LB_FILL:
					if (!loop_record)
					begin
						lb_state_r <= LB_IDLE;
						lb_len_r <= lb_pos_r;
						loop_busy_r <= 1'b0;
					end
					else if (iss && lb_pos_r < PW'(LB_DEPTH))
						lb_pos_r <= lb_pos_r + PW'(1);
				LB_RUN:
					if (iss && !irq)
					begin
						lb_pos_r <= (lb_pos_r == lb_len_r - PW'(1)) ? PW'(0) : lb_pos_r + PW'(1);
						if (lb_pos_r == lb_len_r - PW'(1))
							lb_iter_r <= lb_iter_r - 8'h01;
						if (lb_pos_r == lb_len_r - PW'(1) && lb_iter_r == 8'h01)
						begin
							lb_state_r <= LB_IDLE;
							loop_busy_r <= 1'b0;
						end
					end
				default: lb_state_r <= LB_IDLE;
			endcase
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic [63:0] mul_ref = $signed(a_v[0][U_MUL][31:0]) * $signed(b_v[0][U_MUL][31:0]);
	tsc_stall_a: assert property (stall |=> tsc_r == $past(tsc_r) + 64'h1)
		else $error("counter stopped under stall");
	wide_mul_a: assert property (op[0][U_MUL] == OP_MPY32 |-> res[0][U_MUL].hi == mul_ref[63:32] && res[0][U_MUL].lo == mul_ref[31:0])
		else $error("wide product halves misplaced");
	addsub_par_a: assert property (op[0][U_LOG] == OP_ADDSUB |-> res[0][U_LOG].hi == a_v[0][U_LOG][31:0] + b_v[0][U_LOG][31:0])
		else $error("parallel sum wrong");
	odd_even_a: assert property (res[0][U_SHF].pair |-> hi_idx[0][U_SHF][0] && !lo_idx[0][U_SHF][0])
		else $error("pair routed to wrong parity");
	wdog_exc_a: assert property (watchdog_expire |=> exc_valid_r && exc_cause_r == EXC_WDOG)
		else $error("watchdog not raised");
	illegal_exc_a: assert property (!watchdog_expire && perm_bad == '0 && !fetch_bad && ill_v != '0 |=> exc_cause_r == EXC_ILLEGAL)
		else $error("illegal opcode not raised");
	perm_block_a: assert property (perm_bad[0] |=> !mem_re_a_r && !mem_we_a_r && exc_cause_r != EXC_NONE)
		else $error("page violation went through");
	loop_hold_a: assert property (lb_state_r == LB_RUN && irq |=> $stable(lb_pos_r) && loop_busy_r)
		else $error("replay moved during interrupt");
	compact_add_a: assert property (live[0][U_LOG][F_CMP] && live[0][U_LOG][C_OP +: 3] == 3'h4 && !replay |-> op[0][U_LOG] == OP_ADD && !ins[0][U_LOG][F_S1+3])
		else $error("compact add misdecoded");
	load_ret_a: assert property (mem_rvalid_a |=> rf[0][$past(ld_dst_r[0])] == $past(mem_rdata_a))
		else $error("load data not written");
	replay_c: cover property (lb_state_r == LB_RUN ##1 lb_state_r == LB_IDLE);
	cplx_c: cover property (op[0][U_MUL] == OP_CPLX && iss);
	perm_c: cover property (perm_bad[1] ##1 exc_cause_r == EXC_PERM);
	compact_c: cover property (live[1][U_MUL][F_CMP] && we[1][U_MUL]);
endmodule : dsp_core_dual_datapath
`default_nettype wire

// >>> verification/mem_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Word memory behind one load/store unit; a read is answered one cycle later
module mem_partner
	(
	input wire logic clk,
	input wire logic re,
	input wire logic we,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	output logic rvalid,
	output logic [31:0] rdata
	);
	logic [31:0] mem [16]; // Small image, word index from address bits 5:2
	// Word 0 points at word 1 so that loads can chain from a cleared file
	initial
	begin
		mem[0] = 32'h0000_0004;
		mem[1] = 32'h7fff_8001;
		mem[2] = 32'h0001_7fff;
		for (int i = 3; i < 16; i++)
			mem[i] = 32'h0;
		rvalid = 1'b0;
		rdata = 32'h0;
	end
	// Idle data flips every cycle, so a stale word never passes for a reply
	always @(posedge clk)
	begin
		rvalid <= re;
		rdata <= re ? mem[addr[5:2]] : ~rdata;
		if (we)
			mem[addr[5:2]] <= wdata;
	end
endmodule : mem_partner
`default_nettype wire

// >>> verification/dsp_core_dual_datapath_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_core_dual_datapath_bench;
	import dsp_core_pkg::*;
	logic clk, rst_n, stall, sup, fv, wd, rva, rvb, rea, reb, wea, web, ev;
	logic [31:0] ia [4]; // Side A unit words
	logic [31:0] ib [4]; // Side B unit words
	logic [95:0] perm;
	logic [31:0] fpc, rda, rdb, ada, adb, wda, wdb;
	logic [1:0] ec;
	logic irq, lr, ls, bv, lbusy; // Interrupt, loop controls, branch and loop status
	logic [7:0] lc; // Loop iteration count
	logic [31:0] bt; // Branch target seen
	logic [63:0] tsc, t0;
	int fails, n_tests;
	// Core clock, 100 ns period
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	dsp_core_dual_datapath DUT (.clk(clk), .rst_n(rst_n), .ins_mul_a(ia[0]), .ins_log_a(ia[1]),
		.ins_shf_a(ia[2]), .ins_lds_a(ia[3]), .ins_mul_b(ib[0]), .ins_log_b(ib[1]), .ins_shf_b(ib[2]),
		.ins_lds_b(ib[3]), .stall(stall), .supervisor(sup), .page_perm(perm), .fetch_valid(fv),
		.fetch_pc(fpc), .watchdog_expire(wd), .irq(irq), .loop_record(lr), .loop_start(ls),
		.loop_count(lc), .mem_rdata_a(rda), .mem_rdata_b(rdb), .mem_rvalid_a(rva), .mem_rvalid_b(rvb),
		.mem_addr_a_r(ada), .mem_addr_b_r(adb), .mem_wdata_a_r(wda), .mem_wdata_b_r(wdb),
		.mem_re_a_r(rea), .mem_re_b_r(reb), .mem_we_a_r(wea), .mem_we_b_r(web), .exc_valid_r(ev),
		.exc_cause_r(ec), .branch_valid_r(bv), .branch_target_r(bt), .tsc_r(tsc), .loop_busy_r(lbusy));
	mem_partner pa (.clk(clk), .re(rea), .we(wea), .addr(ada), .wdata(wda), .rvalid(rva), .rdata(rda));
	mem_partner pb (.clk(clk), .re(reb), .we(web), .addr(adb), .wdata(wdb), .rvalid(rvb), .rdata(rdb));
	function automatic logic [31:0] nat(logic [4:0] op, logic [4:0] d, logic [4:0] s1, logic [4:0] s2);
		return {1'b0, op, d, s1, s2, 11'h0};
	endfunction : nat
	task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One word on one unit for one cycle; returns just after the edge that took it
	task automatic issue(int s, int u, logic [31:0] w);
		@(posedge clk);
		if (s == 0)
			ia[u] <= w;
		else
			ib[u] <= w;
		@(posedge clk);
		ia[u] <= 32'h0;
		ib[u] <= 32'h0;
		#1;
	endtask : issue
	// Load, then wait out the partner's reply so the next load keeps its target
	task automatic ld(int s, logic [4:0] d, logic [4:0] s1, logic [4:0] s2, logic [31:0] ea);
		issue(s, U_LDS, nat(OP_LDW, d, s1, s2));
		chk("read strobe", 1'b1, s == 0 ? rea : reb);
		chk("load address", ea, s == 0 ? ada : adb);
		repeat (2) @(posedge clk);
	endtask : ld
	// Store register d to word 0; the written word shows the register's content
	task automatic st(int s, logic [4:0] d, logic [31:0] exp);
		issue(s, U_LDS, nat(OP_STW, d, 5'd0, 5'd0));
		chk("write strobe", 1'b1, s == 0 ? wea : web);
		chk("store data", exp, s == 0 ? wda : wdb);
	endtask : st
	task automatic t_load_store;
		ld(0, 5'd1, 5'd0, 5'd0, 32'h0);
		ld(0, 5'd2, 5'd1, 5'd0, 32'h4);
		ld(0, 5'd3, 5'd1, 5'd1, 32'h8);
		ld(1, 5'd2, 5'd0, 5'd0, 32'h0);
		st(0, 5'd2, 32'h7fff_8001);
		st(1, 5'd2, 32'h0000_0004);
		$display("load and store done");
	endtask : t_load_store
	task automatic t_addsub;
		issue(0, U_LOG, nat(OP_ADDSUB, 5'd4, 5'd2, 5'd3));
		st(0, 5'd5, 32'h8001_0000);
		st(0, 5'd4, 32'h7ffe_0002);
		issue(0, U_LOG, {16'h8000, 3'd4, 3'd6, 3'd2, 3'd3, 4'h0});
		st(0, 5'd6, 32'h8001_0000);
		$display("add and subtract done");
	endtask : t_addsub
	task automatic t_exc;
		issue(0, U_MUL, nat(OP_BAD, 5'd1, 5'd0, 5'd0));
		chk("illegal cause", {1'b1, EXC_ILLEGAL}, {ev, ec});
		st(0, 5'd1, 32'h0000_0004);
		@(posedge clk);
		wd <= 1'b1;
		@(posedge clk);
		wd <= 1'b0;
		#1;
		chk("watchdog cause", {1'b1, EXC_WDOG}, {ev, ec});
		$display("exceptions done");
	endtask : t_exc
	task automatic t_perm;
		@(posedge clk);
		sup <= 1'b0;
		perm[5:0] <= 6'h38;
		issue(0, U_LDS, nat(OP_LDW, 5'd7, 5'd0, 5'd0));
		chk("denied read", 1'b0, rea);
		chk("denied cause", {1'b1, EXC_PERM}, {ev, ec});
		@(posedge clk);
		fv <= 1'b1;
		@(posedge clk);
		fv <= 1'b0;
		perm[5:0] <= 6'h01;
		#1;
		chk("fetch cause", {1'b1, EXC_PERM}, {ev, ec});
		ld(0, 5'd7, 5'd0, 5'd0, 32'h0);
		@(posedge clk);
		sup <= 1'b1;
		perm <= '1;
		$display("permissions done");
	endtask : t_perm
	task automatic t_tsc;
		@(posedge clk);
		stall <= 1'b1;
		#1;
		t0 = tsc;
		issue(0, U_LDS, nat(OP_STW, 5'd1, 5'd0, 5'd0));
		chk("stalled store", 1'b0, wea);
		repeat (3) @(posedge clk);
		#1;
		chk("stamp count", t0 + 64'h5, tsc);
		stall <= 1'b0;
		$display("stamp counter done");
	endtask : t_tsc
	// Wide, complex and rounded complex products, then a branch
	task automatic t_mul;
		issue(0, U_MUL, nat(OP_MPY32, 5'd8, 5'd1, 5'd3));
		st(0, 5'd8, 32'h0005_fffc);
		st(0, 5'd9, 32'h0000_0000);
		issue(0, U_MUL, nat(OP_CPLX, 5'd10, 5'd2, 5'd3));
		st(0, 5'd11, 32'h3fff_8000);
		st(0, 5'd10, 32'h3ffe_8002);
		issue(0, U_MUL, nat(OP_CPLXR, 5'd12, 5'd2, 5'd3));
		st(0, 5'd12, 32'h4000_3fff);
		issue(0, U_SHF, nat(OP_BR, 5'd0, 5'd1, 5'd0));
		chk("branch", {1'b1, 32'h4}, {bv, bt});
		$display("multiply and branch done");
	endtask : t_mul
	// Record one bundle, replay it three times with one interrupt pause
	task automatic t_loop;
		@(posedge clk);
		lr <= 1'b1;
		@(posedge clk);
		ia[1] <= nat(OP_ADD, 5'd13, 5'd13, 5'd1);
		@(posedge clk);
		lr <= 1'b0;
		ia[1] <= 32'h0;
		@(posedge clk);
		ls <= 1'b1;
		lc <= 8'h03;
		@(posedge clk);
		ls <= 1'b0;
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("loop busy", 1'b1, lbusy);
		@(posedge clk);
		#1;
		chk("loop done", 1'b0, lbusy);
		st(0, 5'd13, 32'h0000_0010);
		$display("loop buffer done");
	endtask : t_loop
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	// Hang guard
	initial
	begin
		#2000000;
		fails++;
		end_sim();
	end
	initial
	begin
		rst_n = 1'b0;
		stall = 1'b0;
		sup = 1'b1;
		fv = 1'b0;
		wd = 1'b0;
		irq = 1'b0;
		lr = 1'b0;
		ls = 1'b0;
		lc = 8'h00;
		fpc = 32'h0;
		perm = '1;
		ia = '{4{32'h0}};
		ib = '{4{32'h0}};
		fails = 0;
		n_tests = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_load_store();
		t_addsub();
		t_exc();
		t_perm();
		t_tsc();
		t_mul();
		t_loop();
		end_sim();
	end
endmodule : dsp_core_dual_datapath_bench
`default_nettype wire
